// *** core/pwmlb_top.sv ***
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module pwmlb_top
  import pwmlb_pkg::*;
(
  input wire logic ref_clk, // 250 MHz clock
  input wire logic sys_rst, // Sync reset, active high
  input wire logic [3:0] avs_address, // Word address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Wait request
  input wire logic protect_lock_fuse, // Lock config bit
  input wire logic [15:0] blank_sources, // Candidate blank signals
  input wire logic high_side_output, // High-side PWM output
  input wire logic low_side_output, // Low-side PWM output
  input wire logic fault_in, // Raw fault input
  input wire logic limit_in, // Raw current-limit input
  output logic fault_gated, // Fault after blanking
  output logic limit_gated, // Limit after blanking
  output logic [15:0] output_pin_control, // Output control reg
  output logic [15:0] fault_limit_control // Fault/limit control reg
);
  logic [15:0] leading_edge_blank_ctrl_r;
  logic [15:0] auxiliary_control_r;
  logic [15:0] output_pin_control_r;
  logic [15:0] fault_limit_control_r;
  pwmlb_state_t lk_r;
  logic ack_r;
  logic rejected_r;
  logic [31:0] rd_nxt;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [15:0] wdat;
  logic lo_ok;
  logic hi_ok;
  logic may_prot;
  logic fault_w;
  logic limit_w;
  logic active_w;

  // All checks below run on the one clock and stop during reset
  default clocking ast_cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////
  // Bus slave: every access waits one cycle, answer on the second
  assign req = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r;
  assign rd_go = avs_read & ack_r;
  assign lo_ok = avs_byteenable[0];
  assign hi_ok = avs_byteenable[1];
  assign wdat = avs_writedata[15:0];
  assign may_prot = ~protect_lock_fuse | (lk_r == PWMLB_OPEN);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      ack_r <= req;
      avs_waitrequest <= ~req;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Unlock sequencer; key needs full 16-bit writes
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      lk_r <= PWMLB_LOCKED;
    else if (ack_r & (avs_read | avs_write))
    begin
      case (lk_r)
        PWMLB_LOCKED:
          lk_r <= (wr_go && avs_address == PWMLB_ADDR_KEY && lo_ok && hi_ok
            && wdat == PWMLB_KEY1) ? PWMLB_GOT1 : PWMLB_LOCKED;
        PWMLB_GOT1:
          if (wr_go && avs_address == PWMLB_ADDR_KEY && lo_ok && hi_ok
            && wdat == PWMLB_KEY2)
            lk_r <= PWMLB_OPEN;
          else if (wr_go && avs_address == PWMLB_ADDR_KEY && lo_ok
            && hi_ok && wdat == PWMLB_KEY1)
            lk_r <= PWMLB_GOT1;
          else
            lk_r <= PWMLB_LOCKED;
        PWMLB_OPEN:
          lk_r <= PWMLB_LOCKED;
        default:
          lk_r <= PWMLB_LOCKED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Protected registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      output_pin_control_r <= PWMLB_OUTCTL_RST;
    else if (wr_go && avs_address == PWMLB_ADDR_OUTCTL && may_prot)
    begin
      if (lo_ok)
        output_pin_control_r[7:0] <= wdat[7:0];
      if (hi_ok)
        output_pin_control_r[15:8] <= wdat[15:8];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      fault_limit_control_r <= PWMLB_FLTCTL_RST;
    else if (wr_go && avs_address == PWMLB_ADDR_FLTCTL && may_prot)
    begin
      if (lo_ok)
        fault_limit_control_r[7:0] <= wdat[7:0];
      if (hi_ok)
        fault_limit_control_r[15:8] <= wdat[15:8];
    end
  end

  // Sticky note of a dropped protected write; cleared by a status read
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rejected_r <= 1'b0;
    else if (wr_go && !may_prot && (avs_address == PWMLB_ADDR_OUTCTL
      || avs_address == PWMLB_ADDR_FLTCTL))
      rejected_r <= 1'b1;
    else if (rd_go && avs_address == PWMLB_ADDR_STAT)
      rejected_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Open registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      leading_edge_blank_ctrl_r <= PWMLB_LEB_RST;
    else if (wr_go && avs_address == PWMLB_ADDR_LEB)
    begin
      if (lo_ok)
        leading_edge_blank_ctrl_r[7:0] <= wdat[7:0] & PWMLB_LEB_MASK[7:0];
      if (hi_ok)
        leading_edge_blank_ctrl_r[15:8] <= wdat[15:8]
          & PWMLB_LEB_MASK[15:8];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      auxiliary_control_r <= PWMLB_AUX_RST;
    else if (wr_go && avs_address == PWMLB_ADDR_AUX)
    begin
      if (lo_ok)
        auxiliary_control_r[7:0] <= wdat[7:0];
      if (hi_ok)
        auxiliary_control_r[15:8] <= wdat[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; key reads as zero, unmapped reads zero
  always_comb
  begin
    rd_nxt = 32'h00000000;
    case (avs_address)
      PWMLB_ADDR_OUTCTL: rd_nxt[15:0] = output_pin_control_r;
      PWMLB_ADDR_FLTCTL: rd_nxt[15:0] = fault_limit_control_r;
      PWMLB_ADDR_LEB: rd_nxt[15:0] = leading_edge_blank_ctrl_r;
      PWMLB_ADDR_AUX: rd_nxt[15:0] = auxiliary_control_r;
      PWMLB_ADDR_STAT: rd_nxt[3:0] = {active_w, rejected_r,
        may_prot, protect_lock_fuse};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      avs_readdata <= 32'h00000000;
    else if (req & avs_read)
      avs_readdata <= rd_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  pwmlb_blank u_blank (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .leb_cfg(leading_edge_blank_ctrl_r),
    .blank_sel(blank_sources[auxiliary_control_r[PWMLB_SEL_LSB +:
      PWMLB_SEL_W]]),
    .high_side_output(high_side_output),
    .low_side_output(low_side_output),
    .fault_in(fault_in),
    .limit_in(limit_in),
    .fault_out(fault_w),
    .limit_out(limit_w),
    .leb_active(active_w)
  );

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fault_gated <= 1'b0;
      limit_gated <= 1'b0;
      output_pin_control <= PWMLB_OUTCTL_RST;
      fault_limit_control <= PWMLB_FLTCTL_RST;
    end
    else
    begin
      fault_gated <= fault_w;
      limit_gated <= limit_w;
      output_pin_control <= output_pin_control_r;
      fault_limit_control <= fault_limit_control_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  AST_LOCKED_HOLDS: assert property (
    (wr_go && avs_address == PWMLB_ADDR_OUTCTL && protect_lock_fuse
      && lk_r != PWMLB_OPEN) |=> $stable(output_pin_control_r))
    else $error("locked output control changed");
  AST_FUSE_OFF: assert property (
    (wr_go && avs_address == PWMLB_ADDR_FLTCTL && !protect_lock_fuse
      && lo_ok && hi_ok) |=> fault_limit_control_r == $past(wdat))
    else $error("unprotected write lost");
  // The window may idle open for a while, so only its entry is checked
  AST_KEY_SEQ: assert property (
    ($changed(lk_r) && lk_r == PWMLB_OPEN) |-> $past(lk_r) == PWMLB_GOT1)
    else $error("opened without first key");
  AST_ONE_SHOT: assert property (
    (lk_r == PWMLB_OPEN && ack_r && (avs_read || avs_write))
      |=> lk_r == PWMLB_LOCKED)
    else $error("window stayed open");
  AST_NEXT_ONLY: assert property (
    (wr_go && avs_address == PWMLB_ADDR_OUTCTL && lk_r == PWMLB_OPEN
      && lo_ok && hi_ok) |=> output_pin_control_r == $past(wdat))
    else $error("unlocked write dropped");
  AST_STATE_MASK: assert property (
    (leading_edge_blank_ctrl_r[PWMLB_B_HHI] && high_side_output)
      |=> !fault_gated && !limit_gated)
    else $error("state mask not applied");
  AST_SEL_MASK: assert property (
    (leading_edge_blank_ctrl_r[PWMLB_B_SELLO] && !u_blank.blank_sel)
      |=> !fault_gated)
    else $error("select mask not applied");
  AST_EDGE_BLANK: assert property (
    (u_blank.edge_hit && leading_edge_blank_ctrl_r[PWMLB_B_FLTEN]
      && $stable(leading_edge_blank_ctrl_r))
      |=> ##1 !fault_gated [*8])
    else $error("fault not blanked after edge");
  AST_WAIT_ONE: assert property (
    ($rose(avs_read | avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("slave answer late");
  COV_UNLOCK_WRITE: cover property (@(posedge ref_clk)
    wr_go && lk_r == PWMLB_OPEN && avs_address == PWMLB_ADDR_FLTCTL);
  COV_REJECT: cover property (@(posedge ref_clk) $rose(rejected_r));
  COV_BLANK: cover property (@(posedge ref_clk) $rose(active_w));
endmodule

// *** core/pwmlb_pkg.sv ***
package pwmlb_pkg;
  // Register word addresses on the bus (one 32-bit word each)
  localparam logic [3:0] PWMLB_ADDR_KEY = 4'h0;
  localparam logic [3:0] PWMLB_ADDR_OUTCTL = 4'h1;
  localparam logic [3:0] PWMLB_ADDR_FLTCTL = 4'h2;
  localparam logic [3:0] PWMLB_ADDR_LEB = 4'h3;
  localparam logic [3:0] PWMLB_ADDR_AUX = 4'h4;
  localparam logic [3:0] PWMLB_ADDR_STAT = 4'h5;
  // Unlock key values
  localparam logic [15:0] PWMLB_KEY1 = 16'hABCD;
  localparam logic [15:0] PWMLB_KEY2 = 16'h4321;
  // Reset values
  localparam logic [15:0] PWMLB_LEB_RST = 16'h0000;
  localparam logic [15:0] PWMLB_OUTCTL_RST = 16'h0000;
  localparam logic [15:0] PWMLB_FLTCTL_RST = 16'h0000;
  localparam logic [15:0] PWMLB_AUX_RST = 16'h0000;
  // Blanking control field positions
  localparam int PWMLB_B_HRISE = 15;
  localparam int PWMLB_B_HFALL = 14;
  localparam int PWMLB_B_LRISE = 13;
  localparam int PWMLB_B_LFALL = 12;
  localparam int PWMLB_B_FLTEN = 11;
  localparam int PWMLB_B_LIMEN = 10;
  localparam int PWMLB_B_SELHI = 5;
  localparam int PWMLB_B_SELLO = 4;
  localparam int PWMLB_B_HHI = 3;
  localparam int PWMLB_B_HLO = 2;
  localparam int PWMLB_B_LHI = 1;
  localparam int PWMLB_B_LLO = 0;
  localparam logic [15:0] PWMLB_LEB_MASK = 16'hFC3F;
  // Blank signal select field in the auxiliary control register
  localparam int PWMLB_SEL_LSB = 8;
  localparam int PWMLB_SEL_W = 4;
  // Leading-edge blanking period (cycles), counter width
  localparam int PWMLB_CNT_W = 16;
  localparam logic [15:0] PWMLB_BLANK_LEN = 16'h0010;
  typedef enum logic [1:0] {PWMLB_LOCKED, PWMLB_GOT1, PWMLB_OPEN} pwmlb_state_t;
endpackage

// *** core/pwmlb_blank.sv ***
`timescale 1ns/1ps
module pwmlb_blank
  import pwmlb_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire logic [15:0] leb_cfg, // Blanking control
  input wire logic blank_sel, // Selected blanking signal
  input wire logic high_side_output, // High-side output
  input wire logic low_side_output, // Low-side output
  input wire logic fault_in, // Raw fault
  input wire logic limit_in, // Raw current limit
  output logic fault_out, // Gated fault
  output logic limit_out, // Gated current limit
  output logic leb_active // Edge blanking running
);
  logic hi_d_r;
  logic lo_d_r;
  logic [PWMLB_CNT_W-1:0] cnt_r;
  logic edge_hit;
  logic state_mask;

  assign edge_hit = (leb_cfg[PWMLB_B_HRISE] & high_side_output & ~hi_d_r)
    | (leb_cfg[PWMLB_B_HFALL] & ~high_side_output & hi_d_r)
    | (leb_cfg[PWMLB_B_LRISE] & low_side_output & ~lo_d_r)
    | (leb_cfg[PWMLB_B_LFALL] & ~low_side_output & lo_d_r);

  assign state_mask = (leb_cfg[PWMLB_B_HHI] & high_side_output)
    | (leb_cfg[PWMLB_B_HLO] & ~high_side_output)
    | (leb_cfg[PWMLB_B_LHI] & low_side_output)
    | (leb_cfg[PWMLB_B_LLO] & ~low_side_output)
    | (leb_cfg[PWMLB_B_SELHI] & blank_sel)
    | (leb_cfg[PWMLB_B_SELLO] & ~blank_sel);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      hi_d_r <= 1'b0;
      lo_d_r <= 1'b0;
    end
    else
    begin
      hi_d_r <= high_side_output;
      lo_d_r <= low_side_output;
    end
  end

  // Edge restarts the count even mid-period
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else if (edge_hit)
      cnt_r <= PWMLB_BLANK_LEN;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  assign leb_active = (cnt_r != '0);
  assign fault_out = fault_in & ~state_mask
    & ~(leb_cfg[PWMLB_B_FLTEN] & leb_active);
  assign limit_out = limit_in & ~state_mask
    & ~(leb_cfg[PWMLB_B_LIMEN] & leb_active);
endmodule

// *** tb/tb_pwm_write_lock_blanking.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_pwm_write_lock_blanking;
  import pwmlb_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic fuse = 1'b1;
  logic [15:0] blank_sources = 16'h0000;
  logic hs = 1'b0;
  logic ls = 1'b0;
  logic flt = 1'b1;
  logic lim = 1'b1;
  logic fault_gated;
  logic limit_gated;
  logic [15:0] outctl;
  logic [15:0] fltctl;
  logic [31:0] rd;
  int fails = 0;
  int checks = 0;
  int cyc = 0;

  pwmlb_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .protect_lock_fuse(fuse),
    .blank_sources(blank_sources), .high_side_output(hs),
    .low_side_output(ls), .fault_in(flt), .limit_in(lim),
    .fault_gated(fault_gated), .limit_gated(limit_gated),
    .output_pin_control(outctl), .fault_limit_control(fltctl));

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Cut a hang short; the whole run needs well under this
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Holds the request until waitrequest is sampled low, then releases
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
      fails++;
    @(posedge ref_clk);
  endtask

  task automatic unlock();
    bus(1'b1, PWMLB_ADDR_KEY, 16'hABCD);
    bus(1'b1, PWMLB_ADDR_KEY, 16'h4321);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(1'b0, PWMLB_ADDR_LEB, 16'h0);
    `CHK("leb_rst", 16'h0000, rd[15:0])
    bus(1'b1, PWMLB_ADDR_LEB, 16'hFFFF);
    bus(1'b0, PWMLB_ADDR_LEB, 16'h0);
    `CHK("leb_rw", 16'hFC3F, rd[15:0])
    bus(1'b1, 4'hF, 16'hFFFF);
    bus(1'b0, 4'hF, 16'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask

  task automatic t_lock();
    bus(1'b1, PWMLB_ADDR_OUTCTL, 16'h1111);
    tick(2);
    `CHK("locked_out", 16'h0000, outctl)
    bus(1'b0, PWMLB_ADDR_STAT, 16'h0);
    `CHK("stat_rej", 3'h5, rd[2:0])
    unlock();
    bus(1'b1, PWMLB_ADDR_FLTCTL, 16'h5A5A);
    bus(1'b1, PWMLB_ADDR_OUTCTL, 16'h2222);
    tick(2);
    `CHK("open_flt", 16'h5A5A, fltctl)
    `CHK("one_only", 16'h0000, outctl)
    unlock();
    bus(1'b0, PWMLB_ADDR_LEB, 16'h0);
    bus(1'b1, PWMLB_ADDR_OUTCTL, 16'hBEEF);
    tick(2);
    `CHK("window_used", 16'h0000, outctl)
    unlock();
    bus(1'b1, PWMLB_ADDR_OUTCTL, 16'hF00D);
    bus(1'b0, PWMLB_ADDR_OUTCTL, 16'h0);
    `CHK("second_seq", 16'hF00D, rd[15:0])
    fuse <= 1'b0;
    tick(2);
    bus(1'b1, PWMLB_ADDR_FLTCTL, 16'h1234);
    tick(2);
    `CHK("fuse_off", 16'h1234, fltctl)
    bus(1'b0, PWMLB_ADDR_STAT, 16'h0);
    `CHK("stat_open", 4'h6, rd[3:0])
    fuse <= 1'b1;
    tick(2);
  endtask

  // Reset in mid-run must close an open window; partial keys never count
  task automatic t_reset();
    unlock();
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
    `CHK("rst_mid", 16'h0000, outctl)
    bus(1'b1, PWMLB_ADDR_OUTCTL, 16'h7777);
    tick(2);
    `CHK("rst_locks", 16'h0000, outctl)
    be <= 4'h1;
    unlock();
    be <= 4'hF;
    bus(1'b1, PWMLB_ADDR_OUTCTL, 16'h7777);
    tick(2);
    `CHK("key_be", 16'h0000, outctl)
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Edge triggers stay off here, so only the state masks act
  task automatic t_state();
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, PWMLB_ADDR_LEB, 16'h0C00 | (16'h0001 << i));
      if (i >= 2)
        hs <= (i == 3);
      else
        ls <= (i == 1);
      tick(3);
      `CHK("st_flt", 1'b0, fault_gated)
      `CHK("st_lim", 1'b0, limit_gated)
      if (i >= 2)
        hs <= (i != 3);
      else
        ls <= (i != 1);
      tick(3);
      `CHK("st_off", 2'b11, {fault_gated, limit_gated})
    end
  endtask

  // Other sources sit opposite, so a wrong select index shows
  task automatic t_select();
    bus(1'b1, PWMLB_ADDR_AUX, 16'h0600);
    bus(1'b1, PWMLB_ADDR_LEB, 16'h0C20);
    blank_sources <= 16'hFFBF;
    tick(3);
    `CHK("sel_hi_off", 2'b11, {fault_gated, limit_gated})
    blank_sources <= 16'h0040;
    tick(3);
    `CHK("sel_hi_on", 2'b00, {fault_gated, limit_gated})
    bus(1'b1, PWMLB_ADDR_LEB, 16'h0C10);
    tick(3);
    `CHK("sel_lo_off", 2'b11, {fault_gated, limit_gated})
    blank_sources <= 16'hFFBF;
    tick(3);
    `CHK("sel_lo_on", 2'b00, {fault_gated, limit_gated})
    blank_sources <= 16'h0000;
  endtask

  // Edge order: high rise, high fall, low rise, low fall
  task automatic t_edge();
    logic pre;
    for (int j = 0; j < 5; j++)
    begin
      pre = (j % 2 == 1);
      bus(1'b1, PWMLB_ADDR_LEB,
          (j == 4) ? 16'h8800 : ((16'h8000 >> j) | 16'h0C00));
      if (j < 2 || j == 4)
        hs <= pre;
      else
        ls <= pre;
      tick(25);
      if (j < 2 || j == 4)
        hs <= ~pre;
      else
        ls <= ~pre;
      tick(3);
      if (j == 4)
        `CHK("flt_only", 2'b01, {fault_gated, limit_gated})
      else
        `CHK("edge_blank", 2'b00, {fault_gated, limit_gated})
      bus(1'b0, PWMLB_ADDR_STAT, 16'h0);
      `CHK("stat_act", 1'b1, rd[3])
      tick(25);
      `CHK("edge_end", 2'b11, {fault_gated, limit_gated})
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(16);
    sys_rst <= 1'b0;
    tick(1);
    `CHK("rst_out", 32'h0, {outctl, fltctl})
    t_regs();
    t_lock();
    t_reset();
    t_state();
    t_select();
    t_edge();
    tally_and_finish();
  end
endmodule
